//--- logic/wdprc_pkg.sv
package wdprc_pkg;
   // Register map (byte addresses on the plain register port)
   localparam logic [7:0] ADDR_WDT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PWR_CTRL = 8'h01;
   localparam logic [7:0] ADDR_STATUS   = 8'h02;
   // Watchdog control layout
   localparam int WDC_EN_BIT   = 7;
   localparam int WDC_CLR_BIT  = 6;
   localparam int WDC_IRUN_BIT = 3;
   localparam int WDC_PS_LSB   = 0;
   localparam int PS_W         = 3;
   // Power control layout
   localparam int PWR_POF_BIT  = 4;
   localparam int PWR_GF1_BIT  = 3;
   localparam int PWR_GF0_BIT  = 2;
   localparam int PWR_PD_BIT   = 1;
   localparam int PWR_IDL_BIT  = 0;
   // Status layout
   localparam int ST_WDT_BIT   = 7;
   localparam int ST_EXT_BIT   = 6;
   // Reset values
   localparam logic [7:0] WDT_CTRL_RST = 8'h00;
   localparam logic [7:0] SFR_RST_VAL  = 8'h00;
   localparam logic [7:0] PORT_RST_VAL = 8'hff;
   localparam logic [7:0] SP_RST_VAL   = 8'h07;
   // Timing: two phases per state, six states per machine cycle
   localparam logic [2:0] LAST_STATE   = 3'h5;
   localparam logic [2:0] SAMPLE_STATE = 3'h4;
   localparam logic       SAMPLE_PHASE = 1'b1;
   localparam int WDT_BITS     = 14;
   localparam int PRE_BITS     = 8;
   localparam int RST_SAMPLES  = 2;
   localparam logic [1:0] WDT_RST_MC = 2'h2;
   localparam int PRE_MAX_SHIFT = 8;

   typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_PDOWN} wdprc_pmode_t;

   // Prescale select to log2 of division
   function automatic logic [3:0] wdprc_ps_shift(input logic [PS_W-1:0] sel);
      logic [3:0] s;
      s = 4'h1;
      unique case (sel)
         3'h0: s = 4'h1;
         3'h2: s = 4'h2;
         3'h1: s = 4'h3;
         3'h3: s = 4'h4;
         3'h4: s = 4'h5;
         3'h5: s = 4'h6;
         3'h6: s = 4'h7;
         3'h7: s = 4'h8;
      endcase
      return s;
   endfunction
endpackage

//--- logic/wdprc_rst_filter.sv
`timescale 1ns/100ps
module wdprc_rst_filter
   import wdprc_pkg::*;
#(
   parameter int SAMPLES = RST_SAMPLES
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic rst_pin,
   input  wire logic sample,
   output wire logic rst_out
);
   logic [SAMPLES-2:0] hist_ff;
   logic               out_ff;
   logic [SAMPLES-1:0] win;

   assign win = {hist_ff, rst_pin};

   // Sample history, taken only on the sample strobe
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hist_ff <= '0;
      end else if (sample) begin
         hist_ff <= win[SAMPLES-2:0];
      end
   end

   // Hysteresis: a lone high or low sample never flips the output
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         out_ff <= 1'b0;
      end else if (sample && &win) begin
         out_ff <= 1'b1;
      end else if (sample && ~|win) begin
         out_ff <= 1'b0;
      end
   end

   assign rst_out = out_ff;
endmodule

//--- logic/wdprc_wdt_counter.sv
`timescale 1ns/100ps
module wdprc_wdt_counter
   import wdprc_pkg::*;
#(
   parameter int CNT_W = WDT_BITS,
   parameter int PRE_W = PRE_BITS
) (
   input  wire logic            mclk,
   input  wire logic            reset,
   input  wire logic            mc_tick,
   input  wire logic            run,
   input  wire logic            clear,
   input  wire logic [PS_W-1:0] ps_sel,
   output wire logic [CNT_W-1:0] count,
   output wire logic            timeout
);
   logic [PRE_W-1:0] pre_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             tmo_ff;
   logic [PRE_W-1:0] pre_mask;
   logic             pre_tick;
   logic             step;

   // Prescaler wraps at 2^shift machine cycles
   assign pre_mask = PRE_W'((1 << wdprc_ps_shift(ps_sel)) - 1);
   assign pre_tick = (pre_ff == pre_mask);
   assign step     = run && mc_tick && pre_tick;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pre_ff <= '0;
      end else if (clear) begin
         pre_ff <= '0;
      end else if (run && mc_tick) begin
         pre_ff <= pre_tick ? '0 : PRE_W'(pre_ff + 1'b1);
      end
   end

   // Main count wraps after 2^CNT_W prescaled ticks
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cnt_ff <= '0;
         tmo_ff <= 1'b0;
      end else begin
         tmo_ff <= step && !clear && (&cnt_ff);
         if (clear) begin
            cnt_ff <= '0;
         end else if (step) begin
            cnt_ff <= CNT_W'(cnt_ff + 1'b1);
         end
      end
   end

   assign count   = cnt_ff;
   assign timeout = tmo_ff;

   a_pre_step: assert property (@(posedge mclk) disable iff (reset)
      (cnt_ff != $past(cnt_ff) && !$past(clear)) |-> $past(pre_ff) == $past(pre_mask))
      else $error("watchdog count stepped before prescaler wrap");
endmodule

//--- logic/wdprc_top.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
// Behaviour
// - Watchdog counts only while enabled
// - Clear zeroes counter, prescaler; self-clears
// - Idle-run bit keeps watchdog counting in idle
// - Prescale select picks divide 2 to 256
// - Timeout after 2^14 prescaled machine cycles
// - Clear takes effect next machine cycle
// - Any system reset zeroes watchdog
// - Input clock halved before internal use
// - Idle stops core clock, peripherals run
// - Interrupt or reset ends idle
// - Power-down stops all clocks, oscillator too
// - Only reset ends power-down
// - Reset pin sampled once per cycle, RESET_SAMPLE_PHASE; every edge in power-down
// - Reset pin glitches are filtered out
// - Reset loads ports, stack, SFR defaults
// - Enabled watchdog timeout resets system
// - Power-off flag set at power-on only
module wdprc_top
   import wdprc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       rst_pin,
   input  wire logic       irq_taken,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output wire logic [7:0] rdata,
   output wire logic       core_clk_en,
   output wire logic       periph_clk_en,
   output wire logic       osc_run,
   output wire logic       machine_cycle,
   output wire logic       sys_reset,
   output wire logic       wdt_reset,
   output wire logic [7:0] port_rst_val,
   output wire logic [7:0] sp_rst_val,
   output wire logic [7:0] sfr_rst_val
);
   wdprc_pmode_t          mode_ff;
   wdprc_pmode_t          nxt_mode;
   logic                  phase_ff;
   logic [2:0]            state_ff;
   logic                  mc_ff;
   logic                  en_ff;
   logic                  clr_ff;
   logic                  irun_ff;
   logic [PS_W-1:0]       ps_ff;
   logic                  pof_ff;
   logic                  gf1_ff;
   logic                  gf0_ff;
   logic                  hold_ff;
   logic [1:0]            hold_cnt_ff;
   logic                  wdt_seen_ff;
   logic                  ext_seen_ff;
   logic [7:0]            rdata_ff;
   logic                  ext_rst;
   logic                  sample_pulse;
   logic                  filt_sample;
   logic                  wdt_run;
   logic                  wdt_clear;
   logic [WDT_BITS-1:0]   wdt_count;
   logic                  wdt_timeout;
   logic                  wr_wdt;
   logic                  wr_pwr;
   logic                  wr_st;
   logic                  rst_any;

   assign rst_any = ext_rst || hold_ff;
   assign wr_wdt  = wr_en && (addr == ADDR_WDT_CTRL) && !rst_any;
   assign wr_pwr  = wr_en && (addr == ADDR_PWR_CTRL) && !rst_any;
   assign wr_st   = wr_en && (addr == ADDR_STATUS) && !rst_any;

   // Halved clock: phase toggles each rising edge, so duty cycle of mclk is irrelevant
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         phase_ff <= 1'b0;
      end else if (mode_ff != PM_PDOWN) begin
         phase_ff <= ~phase_ff;
      end
   end

   // State counter S1..S6; one machine cycle is twelve input clocks
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_ff <= 3'h0;
      end else if (mode_ff != PM_PDOWN && phase_ff) begin
         state_ff <= (state_ff == LAST_STATE) ? 3'h0 : 3'(state_ff + 1'b1);
      end
   end

   // Machine-cycle pulse at the end of S6P2
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mc_ff <= 1'b0;
      end else begin
         mc_ff <= (mode_ff != PM_PDOWN) && phase_ff && (state_ff == LAST_STATE);
      end
   end

   // Pin sampled at RESET_SAMPLE_PHASE; in power-down the oscillator is stopped, so the
   // filter is strobed every edge to let a reset wake the part
   assign sample_pulse = (state_ff == SAMPLE_STATE) && (phase_ff == SAMPLE_PHASE);
   assign filt_sample  = sample_pulse || (mode_ff == PM_PDOWN);

   wdprc_rst_filter #(
      .SAMPLES (RST_SAMPLES)
   ) u_filter (
      .mclk    (mclk),
      .reset   (reset),
      .rst_pin (rst_pin),
      .sample  (filt_sample),
      .rst_out (ext_rst)
   );

   // Watchdog control: software fields
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         en_ff   <= WDT_CTRL_RST[WDC_EN_BIT];
         irun_ff <= WDT_CTRL_RST[WDC_IRUN_BIT];
         ps_ff   <= WDT_CTRL_RST[WDC_PS_LSB +: PS_W];
      end else if (rst_any) begin
         en_ff   <= WDT_CTRL_RST[WDC_EN_BIT];
         irun_ff <= WDT_CTRL_RST[WDC_IRUN_BIT];
         ps_ff   <= WDT_CTRL_RST[WDC_PS_LSB +: PS_W];
      end else if (wr_wdt) begin
         en_ff   <= wdata[WDC_EN_BIT];
         irun_ff <= wdata[WDC_IRUN_BIT];
         ps_ff   <= wdata[WDC_PS_LSB +: PS_W];
      end
   end

   // Clear bit: a new write wins over the self-clear in the same cycle
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clr_ff <= 1'b0;
      end else if (rst_any) begin
         clr_ff <= 1'b0;
      end else if (wr_wdt && wdata[WDC_CLR_BIT]) begin
         clr_ff <= 1'b1;
      end else if (mc_ff) begin
         clr_ff <= 1'b0;
      end
   end

   // Counting gate: enable, oscillator alive, idle only if allowed
   assign wdt_run = en_ff && (mode_ff != PM_PDOWN) &&
                    (mode_ff != PM_IDLE || irun_ff);
   assign wdt_clear = (clr_ff && mc_ff) || rst_any;

   wdprc_wdt_counter #(
      .CNT_W (WDT_BITS),
      .PRE_W (PRE_BITS)
   ) u_wdt (
      .mclk    (mclk),
      .reset   (reset),
      .mc_tick (mc_ff),
      .run     (wdt_run),
      .clear   (wdt_clear),
      .ps_sel  (ps_ff),
      .count   (wdt_count),
      .timeout (wdt_timeout)
   );

   // Watchdog reset stretch, counted in machine cycles
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hold_ff     <= 1'b0;
         hold_cnt_ff <= 2'h0;
      end else if (wdt_timeout) begin
         hold_ff     <= 1'b1;
         hold_cnt_ff <= 2'h0;
      end else if (hold_ff && mc_ff) begin
         hold_cnt_ff <= 2'(hold_cnt_ff + 1'b1);
         if (hold_cnt_ff == WDT_RST_MC - 2'h1) begin
            hold_ff <= 1'b0;
         end
      end
   end

   // Power mode: power-down has priority over idle in one write
   always_comb begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         PM_RUN: begin
            if (wr_pwr && wdata[PWR_PD_BIT]) begin
               nxt_mode = PM_PDOWN;
            end else if (wr_pwr && wdata[PWR_IDL_BIT]) begin
               nxt_mode = PM_IDLE;
            end
         end
         PM_IDLE: begin
            if (irq_taken) begin
               nxt_mode = PM_RUN;
            end
         end
         PM_PDOWN: begin
            nxt_mode = PM_PDOWN;
         end
      endcase
      if (rst_any) begin
         nxt_mode = PM_RUN;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mode_ff <= PM_RUN;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // Power control flags; the power-off flag survives warm resets
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pof_ff <= 1'b1;
         gf1_ff <= SFR_RST_VAL[PWR_GF1_BIT];
         gf0_ff <= SFR_RST_VAL[PWR_GF0_BIT];
      end else if (rst_any) begin
         gf1_ff <= SFR_RST_VAL[PWR_GF1_BIT];
         gf0_ff <= SFR_RST_VAL[PWR_GF0_BIT];
      end else if (wr_pwr) begin
         pof_ff <= wdata[PWR_POF_BIT];
         gf1_ff <= wdata[PWR_GF1_BIT];
         gf0_ff <= wdata[PWR_GF0_BIT];
      end
   end

   // Reset cause flags: hardware set wins over a write-one clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wdt_seen_ff <= 1'b0;
         ext_seen_ff <= 1'b0;
      end else begin
         if (wdt_timeout) begin
            wdt_seen_ff <= 1'b1;
         end else if (wr_st && wdata[ST_WDT_BIT]) begin
            wdt_seen_ff <= 1'b0;
         end
         if (ext_rst) begin
            ext_seen_ff <= 1'b1;
         end else if (wr_st && wdata[ST_EXT_BIT]) begin
            ext_seen_ff <= 1'b0;
         end
      end
   end

   // Read data stands one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata_ff <= 8'h00;
      end else if (rd_en) begin
         unique case (addr)
            ADDR_WDT_CTRL: rdata_ff <= {en_ff, clr_ff, 2'h0, irun_ff, ps_ff};
            ADDR_PWR_CTRL: rdata_ff <= {3'h0, pof_ff, gf1_ff, gf0_ff,
                                        mode_ff == PM_PDOWN, mode_ff == PM_IDLE};
            ADDR_STATUS:   rdata_ff <= {wdt_seen_ff, ext_seen_ff,
                                        wdt_count[WDT_BITS-1 -: 6]};
            default:       rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign rdata         = rdata_ff;
   assign core_clk_en   = (mode_ff == PM_RUN);
   assign periph_clk_en = (mode_ff != PM_PDOWN);
   assign osc_run       = (mode_ff != PM_PDOWN);
   assign machine_cycle = mc_ff;
   assign sys_reset     = rst_any;
   assign wdt_reset     = hold_ff;
   // Load values the core applies while sys_reset stands
   assign port_rst_val  = PORT_RST_VAL;
   assign sp_rst_val    = SP_RST_VAL;
   assign sfr_rst_val   = SFR_RST_VAL;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_wdt_run_gate: assert property (
      (!en_ff && !wdt_clear) |=> $stable(wdt_count))
      else $error("watchdog moved while disabled");
   a_clr_self: assert property (
      (clr_ff && mc_ff && !(wr_wdt && wdata[WDC_CLR_BIT])) |=> !clr_ff)
      else $error("clear bit did not fall by itself");
   a_idle_freeze: assert property (
      (mode_ff == PM_IDLE && !irun_ff) |-> !wdt_run)
      else $error("watchdog ran in idle with idle-run off");
   a_tmo_wrap: assert property (
      wdt_timeout |-> (wdt_count == '0) && $past(&wdt_count, 2))
      else $error("timeout not at counter wrap");
   a_clr_apply: assert property (
      (clr_ff && mc_ff) |=> (wdt_count == '0))
      else $error("clear not applied on machine cycle");
   a_rst_zero: assert property (
      rst_any |=> (wdt_count == '0) && !en_ff)
      else $error("reset left watchdog running");
   a_half_clock: assert property (
      (mode_ff != PM_PDOWN) |=> (phase_ff != $past(phase_ff)))
      else $error("internal phase did not toggle");
   a_idle_clocks: assert property (
      (mode_ff == PM_IDLE) |-> !core_clk_en && periph_clk_en)
      else $error("idle clock gating wrong");
   a_idle_exit: assert property (
      (mode_ff == PM_IDLE && irq_taken) |=> (mode_ff == PM_RUN))
      else $error("interrupt did not end idle");
   a_pd_stop: assert property (
      (mode_ff == PM_PDOWN) |-> !osc_run && !periph_clk_en && !core_clk_en)
      else $error("clock left running in power-down");
   a_pd_hold: assert property (
      (mode_ff == PM_PDOWN && !rst_any) |=> (mode_ff == PM_PDOWN))
      else $error("power-down left without reset");
   a_pin_sample: assert property (
      (!filt_sample) |=> $stable(ext_rst))
      else $error("reset pin taken outside RESET_SAMPLE_PHASE");
   a_glitch_gate: assert property (
      $rose(ext_rst) |-> $past(rst_pin))
      else $error("reset asserted from a low sample");
   a_sfr_init: assert property (
      rst_any |=> !gf1_ff && !gf0_ff && !irun_ff && (ps_ff == '0))
      else $error("registers not initialised by reset");
   a_pof_keep: assert property (
      rst_any |=> $stable(pof_ff))
      else $error("warm reset changed power-off flag");
   a_tmo_reset: assert property (
      wdt_timeout |=> hold_ff && sys_reset)
      else $error("timeout gave no system reset");
   // The stretch must start only from a counter timeout, never from the pin
   a_wdt_rst_src: assert property (
      $rose(hold_ff) |-> $past(wdt_timeout))
      else $error("watchdog reset without timeout");
   a_wdt_rst_len: assert property (
      $fell(hold_ff) |-> ($past(hold_cnt_ff) == WDT_RST_MC - 2'h1) && $past(mc_ff))
      else $error("watchdog reset shorter than two machine cycles");
endmodule

//--- verif/watchdog_power_reset_control_tb.sv
`timescale 1ns/100ps
module watchdog_power_reset_control_tb
   import wdprc_pkg::*;
;
   logic        mclk;
   logic        reset;
   logic        rst_pin;
   logic        irq_taken;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rdata;
   logic        core_clk_en;
   logic        periph_clk_en;
   logic        osc_run;
   logic        machine_cycle;
   logic        sys_reset;
   logic        wdt_reset;
   logic [7:0]  port_rst_val;
   logic [7:0]  sp_rst_val;
   logic [7:0]  sfr_rst_val;
   logic        rd_d = 1'b0;
   logic [31:0] lfsr;
   logic [7:0]  exp_q[$];
   logic [7:0]  msk_q[$];
   int          mismatches;
   int          n_tests;
   int          k;

   wdprc_top dut (
      .mclk          (mclk),
      .reset         (reset),
      .rst_pin       (rst_pin),
      .irq_taken     (irq_taken),
      .addr          (addr),
      .wdata         (wdata),
      .wr_en         (wr_en),
      .rd_en         (rd_en),
      .rdata         (rdata),
      .core_clk_en   (core_clk_en),
      .periph_clk_en (periph_clk_en),
      .osc_run       (osc_run),
      .machine_cycle (machine_cycle),
      .sys_reset     (sys_reset),
      .wdt_reset     (wdt_reset),
      .port_rst_val  (port_rst_val),
      .sp_rst_val    (sp_rst_val),
      .sfr_rst_val   (sfr_rst_val)
   );

   // 250 MHz oscillator
   always #2 mclk = ~mclk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Bus tasks drive right after an edge and hold until the next one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      @(posedge mclk);
   endtask

   // Expected data is noted here; the monitor compares one cycle later
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      addr  <= a;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge mclk);
   endtask

   task automatic idle_n(input int n);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask

   // Bounded wait so a stuck reset cannot hang the run
   task automatic wait_rst(input logic v, input int lim);
      int i;
      i = 0;
      while (sys_reset !== v && i < lim) begin
         @(posedge mclk);
         i++;
      end
      // Pin is held until two sample points saw it; running out is a fault
      if (i >= lim)
         check("sys_reset", {7'h00, sys_reset}, {7'h00, v});
   endtask

   // Strobes drop here too, so a read just before never repeats
   task automatic pulse_irq();
      irq_taken <= 1'b1;
      wr_en     <= 1'b0;
      rd_en     <= 1'b0;
      @(posedge mclk);
      irq_taken <= 1'b0;
      idle_n(3);
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rd_d) begin
         check("rdata", rdata & msk_q[0], exp_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      rd_d <= rd_en;
   end

   // Budget is roughly twice the expected run length
   initial begin
      repeat (90000) @(posedge mclk);
      mismatches++;
      give_verdict();
   end

   initial begin
      mclk = 1'b0; reset = 1'b1; rst_pin = 1'b0; irq_taken = 1'b0;
      addr = 8'h00; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
      lfsr = 32'hce77a48e; mismatches = 0; n_tests = 0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      check("core_clk_en", {7'h00, core_clk_en}, 8'h01);
      check("osc_run", {7'h00, osc_run}, 8'h01);
      check("sys_reset", {7'h00, sys_reset}, 8'h00);
      check("port_rst_val", port_rst_val, 8'hff);
      check("sp_rst_val", sp_rst_val, 8'h07);
      check("sfr_rst_val", sfr_rst_val, 8'h00);
      rd(ADDR_WDT_CTRL, WDT_CTRL_RST, 8'hff);
      rd(ADDR_PWR_CTRL, 8'h10, 8'hff);
      rd(ADDR_STATUS, 8'h00, 8'h3f);
      $display("test reset values done");
      // Every prescale code, random idle-run bit, counter left disabled
      for (k = 0; k < 8; k++) begin
         lfsr = lfsr_next(lfsr);
         wr(ADDR_WDT_CTRL, {4'h0, lfsr[0], k[2:0]});
         rd(ADDR_WDT_CTRL, {4'h0, lfsr[0], k[2:0]}, 8'hff);
      end
      lfsr = lfsr_next(lfsr);
      wr({lfsr[7:2], 2'h3}, 8'hff);
      rd({lfsr[7:2], 2'h3}, 8'h00, 8'hff);
      rd(ADDR_PWR_CTRL, 8'h10, 8'hff);
      idle_n(9000);
      rd(ADDR_STATUS, 8'h00, 8'h3f);
      $display("test prescale codes and disabled counter done");
      // 750 machine cycles over 2 gives 375 counts, so bits 13:8 hold 1
      wr(ADDR_WDT_CTRL, 8'h80);
      idle_n(9000);
      rd(ADDR_STATUS, 8'h01, 8'h3f);
      wr(ADDR_WDT_CTRL, 8'hc0);
      idle_n(30);
      rd(ADDR_WDT_CTRL, 8'h80, 8'hff);
      rd(ADDR_STATUS, 8'h00, 8'h3f);
      wr(ADDR_WDT_CTRL, 8'hc2);
      idle_n(9000);
      rd(ADDR_STATUS, 8'h00, 8'h3f);
      $display("test counting and clear done");
      // Idle with the idle-run bit low freezes the counter
      wr(ADDR_WDT_CTRL, 8'hc0);
      idle_n(30);
      wr(ADDR_PWR_CTRL, 8'h11);
      idle_n(3);
      check("core_clk_en", {7'h00, core_clk_en}, 8'h00);
      check("periph_clk_en", {7'h00, periph_clk_en}, 8'h01);
      idle_n(9000);
      rd(ADDR_STATUS, 8'h00, 8'h3f);
      pulse_irq();
      check("core_clk_en", {7'h00, core_clk_en}, 8'h01);
      wr(ADDR_WDT_CTRL, 8'hc8);
      idle_n(30);
      wr(ADDR_PWR_CTRL, 8'h11);
      idle_n(9000);
      rd(ADDR_STATUS, 8'h01, 8'h3f);
      pulse_irq();
      $display("test idle done");
      // Power-down ignores an interrupt and leaves only through reset
      wr(ADDR_PWR_CTRL, 8'h1e);
      idle_n(3);
      check("osc_run", {7'h00, osc_run}, 8'h00);
      check("periph_clk_en", {7'h00, periph_clk_en}, 8'h00);
      pulse_irq();
      check("osc_run", {7'h00, osc_run}, 8'h00);
      rst_pin <= 1'b1;
      wait_rst(1'b1, 50);
      check("sys_reset", {7'h00, sys_reset}, 8'h01);
      check("wdt_reset", {7'h00, wdt_reset}, 8'h00);
      rst_pin <= 1'b0;
      wait_rst(1'b0, 100);
      idle_n(2);
      check("osc_run", {7'h00, osc_run}, 8'h01);
      check("core_clk_en", {7'h00, core_clk_en}, 8'h01);
      rd(ADDR_WDT_CTRL, 8'h00, 8'hff);
      rd(ADDR_STATUS, 8'h00, 8'h3f);
      rd(ADDR_PWR_CTRL, 8'h10, 8'hff);
      $display("test power-down done");
      // Cleared power-off flag survives a warm reset; writes blocked
      wr(ADDR_PWR_CTRL, 8'h0c);
      rd(ADDR_PWR_CTRL, 8'h0c, 8'hff);
      idle_n(1);
      rst_pin <= 1'b1;
      wait_rst(1'b1, 50);
      wr(ADDR_WDT_CTRL, 8'h85);
      idle_n(1);
      rst_pin <= 1'b0;
      wait_rst(1'b0, 100);
      idle_n(2);
      rd(ADDR_PWR_CTRL, 8'h00, 8'hff);
      rd(ADDR_WDT_CTRL, 8'h00, 8'hff);
      $display("test warm reset done");
      // A pulse shorter than one machine cycle gets one sample at most
      rst_pin <= 1'b1;
      idle_n(10);
      rst_pin <= 1'b0;
      for (k = 0; k < 40; k++) begin
         if (sys_reset !== 1'b0)
            check("sys_reset", {7'h00, sys_reset}, 8'h00);
         @(posedge mclk);
      end
      k = 0;
      while (machine_cycle !== 1'b1 && k < 30) begin
         @(posedge mclk);
         k++;
      end
      @(posedge mclk);
      k = 1;
      while (machine_cycle !== 1'b1 && k < 30) begin
         @(posedge mclk);
         k++;
      end
      check("machine_period", k[7:0], 8'h0c);
      $display("test glitch and machine cycle done");
      idle_n(4);
      give_verdict();
   end
endmodule
